// [verilog/tx_pcs_defs.vh]
/*
 * Constants for the 100 Mbps transmit coding path: code-groups,
 * scrambler width and seed, clock rates and serial layout.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef TX_PCS_DEFS_VH
`define TX_PCS_DEFS_VH

`define CG_J 5'h18
`define CG_K 5'h11
`define CG_T 5'h0d
`define CG_R 5'h07
`define CG_IDLE 5'h1f
`define CG_HALT 5'h04
`define CG_LPI 5'h00
`define LPI_NIBBLE 4'h1
`define SCR_WIDTH 11
`define SCR_SEED 11'h7ff
`define CG_WIDTH 5
`define NIBBLE_WIDTH 4
`define FIFO_DEPTH 16
`define SYM_CLK_MHZ 125
`define SYS_CLK_MHZ 200
`define REF_CLK_MHZ 50
`define LINE_MBPS 125

`endif

// [verilog/nibble_fifo.v]
/*
 * Synchronous FIFO with valid/ready handshake on both sides.
 * Assumes one clock, active-low asynchronous reset and a clock enable.
 */
`timescale 1ns/1ps
module nibble_fifo #(
	parameter WIDTH = 6,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock and reset
	input wire clk_in,
	input wire resetn_in,
	input wire ce_in,
	// Write side
	input wire wr_valid_in,
	output wire wr_ready_out,
	input wire [WIDTH-1:0] wr_data_in,
	// Read side
	output wire rd_valid_out,
	input wire rd_ready_in,
	output wire [WIDTH-1:0] rd_data_out
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wr_ptr_q;
reg [AW-1:0] rd_ptr_q;
reg [AW:0] count_q;
wire push;
wire pop;

assign wr_ready_out = (count_q != DEPTH[AW:0]);
assign rd_valid_out = (count_q != {(AW+1){1'b0}});
assign rd_data_out = mem[rd_ptr_q];
assign push = ce_in & wr_valid_in & wr_ready_out;
assign pop = ce_in & rd_valid_out & rd_ready_in;

always @(posedge clk_in) begin
	if (push) begin
		mem[wr_ptr_q] <= wr_data_in;
	end
end

always @(posedge clk_in or negedge resetn_in) begin
	if (!resetn_in) begin
		wr_ptr_q <= {AW{1'b0}};
		rd_ptr_q <= {AW{1'b0}};
		count_q <= {(AW+1){1'b0}};
	end else begin
		if (push) begin
			wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ?
				{AW{1'b0}} : wr_ptr_q + 1'b1;
		end
		if (pop) begin
			rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ?
				{AW{1'b0}} : rd_ptr_q + 1'b1;
		end
		if (push && !pop) begin
			count_q <= count_q + 1'b1;
		end else if (pop && !push) begin
			count_q <= count_q - 1'b1;
		end
	end
end

endmodule

// [verilog/fast_ethernet_tx_pcs_encoder.v]
/*
 * Transmit coding path for 100 Mbps twisted pair: dibit assembly,
 * FIFO, 4B5B encoding with J/K, T/R, idle, halt and LPI injection,
 * serialisation, scrambling with bypass, NRZI, plus a code-group
 * checker. Assumes clk_in is the symbol clock and that the dibit
 * side presents a strobe once per reference-clock cycle.
 */
// Operation
// - Map each nibble to its data code-group
// - Replace first preamble byte with J/K
// - Remaining nibbles become data code-groups
// - Append T/R when enable drops
// - Send idle until next enable
// - Halt code-group marks errored nibbles inside a frame
// - LPI nibble with error maps to 00000
// - Decode flags invalid codes, and control codes inside data
// - Scrambler is closed-loop 11-bit LFSR
// - XOR each serial bit with LFSR
// - Scrambler bypass passes code unscrambled
// - NRZI stage always active
// - Line stream one bit per symbol
// - Sequencing follows standard transmit machine
// - Encode, scramble, NRZI, then driver
// - Two bits per reference cycle assembled
`timescale 1ns/1ps
`include "tx_pcs_defs.vh"
module fast_ethernet_tx_pcs_encoder #(
	parameter FIFO_DEPTH = `FIFO_DEPTH,
	parameter FIFO_AW = 4
) (
	// Clock, reset, enable
	input wire clk_in,
	input wire resetn_in,
	input wire ce_in,
	// Dibit side from the MAC
	input wire dibit_stb_in,
	input wire [1:0] tx_dibit_in,
	input wire tx_en_in,
	input wire tx_er_in,
	output reg dibit_ready_out,
	// Configuration
	input wire scr_bypass_in,
	// Line side
	output reg line_nrzi_out,
	output reg line_active_out,
	// Code-group checker
	input wire [4:0] chk_group_in,
	input wire chk_in_data_in,
	output reg chk_err_out,
	output reg [3:0] chk_nibble_out
);

localparam ST_IDLE = 3'h0;
localparam ST_K = 3'h1;
localparam ST_DATA = 3'h2;
localparam ST_R = 3'h3;
localparam ST_LPI = 3'h4;
localparam FW = 6;

////////////////////////////////////////////////////////////////////////
// Dibit assembly

reg [1:0] low_pair_q;
reg half_q;
reg fifo_wr_q;
reg [FW-1:0] fifo_wdata_q;
wire fifo_wr_ready;
wire fifo_rd_valid;
wire [FW-1:0] fifo_rdata;
reg fifo_pop;

always @(posedge clk_in or negedge resetn_in) begin
	if (!resetn_in) begin
		low_pair_q <= 2'h0;
		half_q <= 1'b0;
		fifo_wr_q <= 1'b0;
		fifo_wdata_q <= {FW{1'b0}};
		dibit_ready_out <= 1'b0;
	end else if (ce_in) begin
		dibit_ready_out <= fifo_wr_ready;
		if (fifo_wr_q && fifo_wr_ready) begin
			fifo_wr_q <= 1'b0;
		end
		if (dibit_stb_in && (tx_en_in || tx_er_in)) begin
			if (!half_q) begin
				low_pair_q <= tx_dibit_in;
				half_q <= 1'b1;
			end else begin
				fifo_wdata_q <= {tx_en_in, tx_er_in, tx_dibit_in,
					low_pair_q};
				fifo_wr_q <= 1'b1;
				half_q <= 1'b0;
			end
		end else if (dibit_stb_in) begin
			half_q <= 1'b0;
		end
	end
end

nibble_fifo #(
	.WIDTH(FW),
	.DEPTH(FIFO_DEPTH),
	.AW(FIFO_AW)
) u_fifo (
	.clk_in(clk_in),
	.resetn_in(resetn_in),
	.ce_in(ce_in),
	.wr_valid_in(fifo_wr_q),
	.wr_ready_out(fifo_wr_ready),
	.wr_data_in(fifo_wdata_q),
	.rd_valid_out(fifo_rd_valid),
	.rd_ready_in(fifo_pop),
	.rd_data_out(fifo_rdata)
);

////////////////////////////////////////////////////////////////////////
// 4B5B table

function [4:0] enc4b5b;
	input [3:0] n;
	begin
		case (n)
		4'h0: enc4b5b = 5'h1e;
		4'h1: enc4b5b = 5'h09;
		4'h2: enc4b5b = 5'h14;
		4'h3: enc4b5b = 5'h15;
		4'h4: enc4b5b = 5'h0a;
		4'h5: enc4b5b = 5'h0b;
		4'h6: enc4b5b = 5'h0e;
		4'h7: enc4b5b = 5'h0f;
		4'h8: enc4b5b = 5'h12;
		4'h9: enc4b5b = 5'h13;
		4'ha: enc4b5b = 5'h16;
		4'hb: enc4b5b = 5'h17;
		4'hc: enc4b5b = 5'h1a;
		4'hd: enc4b5b = 5'h1b;
		4'he: enc4b5b = 5'h1c;
		default: enc4b5b = 5'h1d;
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////
// Frame sequencer, one code-group per five symbol clocks

reg [2:0] state_q;
reg [2:0] state_d;
reg [4:0] group_d;
reg [4:0] shift_q;
reg [2:0] bit_cnt_q;
reg skip_q;
reg skip_d;
wire group_due;
wire f_en;
wire f_er;
wire [3:0] f_nib;

assign group_due = (bit_cnt_q == 3'h0);
assign f_en = fifo_rdata[5];
assign f_er = fifo_rdata[4];
assign f_nib = fifo_rdata[3:0];

always @* begin
	state_d = state_q;
	group_d = `CG_IDLE;
	skip_d = skip_q;
	fifo_pop = 1'b0;
	if (group_due) begin
		case (state_q)
		ST_IDLE: begin
			group_d = `CG_IDLE;
			if (fifo_rd_valid && f_en) begin
				group_d = `CG_J;
				fifo_pop = 1'b1;
				skip_d = 1'b1;
				state_d = ST_K;
			end else if (fifo_rd_valid && f_er &&
				f_nib == `LPI_NIBBLE) begin
				group_d = `CG_LPI;
				fifo_pop = 1'b1;
				state_d = ST_LPI;
			end else if (fifo_rd_valid) begin
				fifo_pop = 1'b1;
			end
		end
		ST_K: begin
			// second preamble nibble absorbed by K
			group_d = `CG_K;
			// Limitation: a nibble late for K is sent as data
			if (skip_q && fifo_rd_valid && f_en) begin
				fifo_pop = 1'b1;
				skip_d = 1'b0;
			end
			state_d = ST_DATA;
		end
		ST_DATA: begin
			if (fifo_rd_valid && f_en) begin
				fifo_pop = 1'b1;
				if (f_er) begin
					group_d = `CG_HALT;
				end else begin
					group_d = enc4b5b(f_nib);
				end
			end else begin
				group_d = `CG_T;
				state_d = ST_R;
			end
		end
		ST_R: begin
			group_d = `CG_R;
			state_d = ST_IDLE;
		end
		ST_LPI: begin
			group_d = `CG_LPI;
			if (fifo_rd_valid) begin
				fifo_pop = !f_en && f_er && f_nib == `LPI_NIBBLE;
				if (!fifo_pop) begin
					group_d = `CG_IDLE;
					state_d = ST_IDLE;
				end
			end else begin
				group_d = `CG_IDLE;
				state_d = ST_IDLE;
			end
		end
		default: begin
			state_d = ST_IDLE;
		end
		endcase
	end
end

////////////////////////////////////////////////////////////////////////
// Serialiser, scrambler and NRZI

reg [`SCR_WIDTH-1:0] lfsr_q;
wire lfsr_fb;
wire nrz_bit;
wire scr_bit;
wire [4:0] load_group;

assign load_group = group_d;
// x^11 + x^9 + 1 closed loop
assign lfsr_fb = lfsr_q[10] ^ lfsr_q[8];
// MSB of the code-group leaves first
assign nrz_bit = group_due ? load_group[4] : shift_q[4];
assign scr_bit = scr_bypass_in ? nrz_bit : (nrz_bit ^ lfsr_fb);

always @(posedge clk_in or negedge resetn_in) begin
	if (!resetn_in) begin
		state_q <= ST_IDLE;
		skip_q <= 1'b0;
		shift_q <= `CG_IDLE;
		bit_cnt_q <= 3'h0;
		lfsr_q <= `SCR_SEED;
		line_nrzi_out <= 1'b0;
		line_active_out <= 1'b0;
	end else if (ce_in) begin
		state_q <= state_d;
		skip_q <= skip_d;
		// one line bit every symbol clock
		if (group_due) begin
			shift_q <= {load_group[3:0], 1'b0};
			bit_cnt_q <= 3'h4;
		end else begin
			shift_q <= {shift_q[3:0], 1'b0};
			bit_cnt_q <= bit_cnt_q - 3'h1;
		end
		lfsr_q <= {lfsr_q[9:0], lfsr_fb};
		line_nrzi_out <= line_nrzi_out ^ scr_bit;
		line_active_out <= (state_q != ST_IDLE);
	end
end

////////////////////////////////////////////////////////////////////////
// Code-group checker for the receive direction

always @(posedge clk_in or negedge resetn_in) begin
	if (!resetn_in) begin
		chk_err_out <= 1'b0;
		chk_nibble_out <= 4'h0;
	end else if (ce_in) begin
		chk_err_out <= 1'b0;
		chk_nibble_out <= 4'h0;
		case (chk_group_in)
		5'h1e: chk_nibble_out <= 4'h0;
		5'h09: chk_nibble_out <= 4'h1;
		5'h14: chk_nibble_out <= 4'h2;
		5'h15: chk_nibble_out <= 4'h3;
		5'h0a: chk_nibble_out <= 4'h4;
		5'h0b: chk_nibble_out <= 4'h5;
		5'h0e: chk_nibble_out <= 4'h6;
		5'h0f: chk_nibble_out <= 4'h7;
		5'h12: chk_nibble_out <= 4'h8;
		5'h13: chk_nibble_out <= 4'h9;
		5'h16: chk_nibble_out <= 4'ha;
		5'h17: chk_nibble_out <= 4'hb;
		5'h1a: chk_nibble_out <= 4'hc;
		5'h1b: chk_nibble_out <= 4'hd;
		5'h1c: chk_nibble_out <= 4'he;
		5'h1d: chk_nibble_out <= 4'hf;
		`CG_IDLE, `CG_J, `CG_K, `CG_T, `CG_R: begin
			chk_err_out <= chk_in_data_in;
		end
		`CG_LPI: begin
			// LPI reported with error, no valid
			chk_nibble_out <= `LPI_NIBBLE;
			chk_err_out <= 1'b1;
		end
		default: begin
			chk_err_out <= 1'b1;
		end
		endcase
	end
end

endmodule

// [tb/cg_tab.svh]
/* 4B5B data code table and its reverse lookup.
   Assumes inclusion inside a module body. */
localparam [79:0] dtab = {5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h17, 5'h16, 5'h13,
	5'h12, 5'h0f, 5'h0e, 5'h0b, 5'h0a, 5'h15, 5'h14, 5'h09, 5'h1e};
// Returns 5'h10 for any non-data group
function automatic [4:0] dec(input [4:0] c);
	dec = 5'h10;
	for (int i = 0; i < 16; i++)
		if (dtab[i*5+:5] == c)
			dec = i[4:0];
endfunction

// [tb/tx_pcs_props.sv]
/* Port checker for the transmit coding block.
   Assumes a bind to the top module, one clock. */
`timescale 1ns/1ps
module tx_pcs_props (
	// Control
	input wire clk_in,
	input wire resetn_in,
	input wire ce_in,
	// Line and buffer
	input wire line_nrzi_out,
	input wire line_active_out,
	input wire dibit_ready_out,
	// Code-group checker
	input wire [4:0] chk_group_in,
	input wire chk_in_data_in,
	input wire chk_err_out,
	input wire [3:0] chk_nibble_out
);
`include "cg_tab.svh"
	logic [4:0] exp_q;
	logic dat, inv, ctl;
	assign dat = resetn_in && ce_in && dec(chk_group_in) != 5'h10;
	assign inv = resetn_in && ce_in && chk_group_in inside {5'h01, 5'h02,
		5'h03, 5'h05, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h19};
	assign ctl = resetn_in && ce_in && chk_group_in inside {5'h1f, 5'h18,
		5'h11, 5'h0d, 5'h07};
	always @(posedge clk_in)
		exp_q <= dec(chk_group_in);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	chk_data_decode: assert property (dat |=>
		!chk_err_out && chk_nibble_out == exp_q[3:0])
		else $error("data group misdecoded");
	chk_invalid_flag: assert property (inv |=>
		chk_err_out && chk_nibble_out == 4'h0)
		else $error("invalid group not flagged");
	chk_ctrl_data: assert property (ctl && chk_in_data_in |=>
		chk_err_out) else $error("control in data not flagged");
	chk_ctrl_idle: assert property (ctl && !chk_in_data_in |=>
		!chk_err_out) else $error("control flagged outside data");
	chk_lpi_decode: assert property (resetn_in && ce_in &&
		chk_group_in == 5'h00 |=> chk_err_out && chk_nibble_out == 4'h1)
		else $error("lpi misdecoded");
	chk_halt_err: assert property (resetn_in && ce_in &&
		chk_group_in == 5'h04 |=> chk_err_out)
		else $error("halt not flagged");
	chk_ready_reset: assert property ($rose(resetn_in) |->
		##[0:2] dibit_ready_out) else $error("buffer not ready");
	chk_ce_freeze: assert property (!ce_in |=>
		$stable(line_nrzi_out) && $stable(line_active_out))
		else $error("line moved while frozen");
	cov_frame: cover property ($rose(line_active_out));
	cov_full: cover property (!dibit_ready_out);
	cov_lpi: cover property (ce_in && chk_group_in == 5'h00);
endmodule
bind fast_ethernet_tx_pcs_encoder tx_pcs_props i_props (.clk_in, .resetn_in,
	.ce_in, .line_nrzi_out, .line_active_out, .dibit_ready_out,
	.chk_group_in, .chk_in_data_in, .chk_err_out, .chk_nibble_out);

// [tb/mac_dibit_model.sv]
/* MAC source: strobed dibits with enable and error.
   Assumes entries of {en, er, nibble} from the bench. */
`timescale 1ns/1ps
module mac_dibit_model (
	// Clock
	input wire clk_in,
	// Dibit stream
	output logic stb_out = 1'b0,
	output logic [1:0] dibit_out = 2'h0,
	output logic en_out = 1'b0,
	output logic er_out = 1'b0
);
	// Gap of one overruns the buffer on purpose
	task automatic send(input logic [5:0] q[$], input int gap);
		foreach (q[i])
			for (int h = 0; h < 2; h++) begin
				@(posedge clk_in);
				stb_out <= 1'b1;
				dibit_out <= h ? q[i][3:2] : q[i][1:0];
				{en_out, er_out} <= q[i][5:4];
				repeat (gap - 1) begin
					@(posedge clk_in);
					stb_out <= 1'b0;
					dibit_out <= ~dibit_out;
				end
			end
		@(posedge clk_in);
		{stb_out, en_out, er_out} <= 3'h0;
	endtask
endmodule

// [tb/tb_fast_ethernet_tx_pcs_encoder.sv]
/* Self-checking bench for the transmit coding block.
   Assumes the MAC model, the bound checker and the code table. */
`timescale 1ns/1ps
`include "tx_pcs_defs.vh"
module tb_fast_ethernet_tx_pcs_encoder;
`include "cg_tab.svh"
	logic clk_in, resetn_in, ce_in, stb, en, er, byp, nrzi, act, rdy;
	logic prev_q, in_data, err;
	logic [1:0] dib;
	logic [4:0] grp;
	logic [3:0] nib;
	logic [9:0] sr_q;
	logic [5:0] fr[$];
	int num_errors, n_checks;
	fast_ethernet_tx_pcs_encoder i_dut (.clk_in, .resetn_in, .ce_in,
		.dibit_stb_in(stb), .tx_dibit_in(dib), .tx_en_in(en),
		.tx_er_in(er), .dibit_ready_out(rdy), .scr_bypass_in(byp),
		.line_nrzi_out(nrzi), .line_active_out(act), .chk_group_in(grp),
		.chk_in_data_in(in_data), .chk_err_out(err), .chk_nibble_out(nib));
	mac_dibit_model i_mac (.clk_in, .stb_out(stb), .dibit_out(dib),
		.en_out(en), .er_out(er));
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	// Line turned back to NRZ, newest bit low
	always @(posedge clk_in) begin
		prev_q <= nrzi;
		sr_q <= {sr_q[8:0], nrzi ^ prev_q};
	end
	task automatic cmp(string n, logic [9:0] e, logic [9:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic hunt(logic [9:0] p, string n);
		int k;
		k = 0;
		do begin
			@(posedge clk_in);
			#1;
			k++;
		end while (sr_q !== p && k < 400);
		cmp(n, p, sr_q);
	endtask
	task automatic take(logic [4:0] e, string n);
		repeat (5) @(posedge clk_in);
		#1;
		cmp(n, {5'h00, e}, {5'h00, sr_q[4:0]});
	endtask
	task automatic s_frame();
		fr = {6'h25, 6'h25};
		for (int i = 0; i < 16; i++)
			fr.push_back({2'h2, i[3:0]});
		fork
			i_mac.send(fr, 2);
			begin
				hunt({`CG_J, `CG_K}, "start");
				for (int i = 0; i < 16; i++)
					take(dtab[i*5+:5], "data");
				take(`CG_T, "end t");
				take(`CG_R, "end r");
				take(`CG_IDLE, "idle");
			end
		join
	endtask
	task automatic s_ctrl();
		fr = {6'h25, 6'h25, 6'h33, 6'h20, 6'h20};
		fork
			i_mac.send(fr, 2);
			hunt({`CG_K, `CG_HALT}, "halt");
		join
		fr = {6'h11, 6'h11, 6'h11, 6'h11, 6'h11, 6'h11};
		fork
			i_mac.send(fr, 2);
			hunt({`CG_LPI, `CG_LPI}, "lpi");
		join
	endtask
	task automatic s_scr();
		int ones;
		ones = 0;
		// Let the LPI tail drain so the line is idle
		repeat (60) @(posedge clk_in);
		#1;
		cmp("bypass idle", 10'h3ff, sr_q);
		@(posedge clk_in);
		byp <= 1'b0;
		repeat (12) @(posedge clk_in);
		repeat (60) begin
			@(posedge clk_in);
			#1;
			ones += sr_q[0];
		end
		cmp("scrambled", 10'h3, {8'h0, ones > 0, ones < 60});
		@(posedge clk_in);
		byp <= 1'b1;
		repeat (12) @(posedge clk_in);
		#1;
		cmp("bypass back", 10'h3ff, sr_q);
	endtask
	task automatic s_fill();
		int lo;
		lo = 0;
		fr = {};
		repeat (60) fr.push_back(6'h2a);
		fork
			i_mac.send(fr, 1);
			repeat (140) begin
				@(posedge clk_in);
				#1;
				lo += (rdy === 1'b0);
			end
		join
		cmp("full", 10'h1, {9'h0, lo > 0});
		repeat (400) @(posedge clk_in);
		#1;
		cmp("drained", 10'h3, {8'h0, rdy, ~act});
	endtask
	task automatic s_dec();
		logic [4:0] d, e;
		for (int h = 0; h < 2; h++)
			for (int g = 0; g < 32; g++) begin
				@(posedge clk_in);
				grp <= g[4:0];
				in_data <= h[0];
				@(posedge clk_in);
				#1;
				d = dec(g[4:0]);
				e = d[4] ? {!(h == 0 && g inside {5'h1f, 5'h18, 5'h11,
					5'h0d, 5'h07}), 3'h0, g == 0} : {1'b0, d[3:0]};
				cmp("decode", {5'h0, e}, {5'h0, err, nib});
			end
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#40000;
		num_errors++;
		end_sim();
	end
	initial begin
		{resetn_in, ce_in, byp, in_data, grp} = 9'h0e0;
		num_errors = 0;
		n_checks = 0;
		repeat (8) @(posedge clk_in);
		resetn_in <= 1'b1;
		repeat (20) @(posedge clk_in);
		s_frame();
		s_ctrl();
		s_scr();
		s_fill();
		s_dec();
		@(posedge clk_in);
		ce_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		ce_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		end_sim();
	end
endmodule
